// ### dscc_regs.svh
// Constants for the selective-calling character codec control block.
`ifndef DSCC_REGS_SVH
`define DSCC_REGS_SVH
`define DSCC_MCTL_SELECT_BIT 11
`define DSCC_MCTL_IGNORE_MSB 8
`define DSCC_MODE_RUN_BIT 2
`define DSCC_PW0_ENH_BIT 10
`define DSCC_BIT_RATE_BPS 1200
`define DSCC_CLK_HZ 125000000
`define DSCC_BIT_CYCLES (`DSCC_CLK_HZ / `DSCC_BIT_RATE_BPS)
`define DSCC_TONE_ONE_HZ 1300
`define DSCC_TONE_ZERO_HZ 2100
`define DSCC_CHAR_BITS 10
`define DSCC_INFO_BITS 7
`endif

// ### dscc_pkg.sv
// Types shared by the selective-calling codec control block.
package dscc_pkg;
   typedef enum logic [1:0] {
      DSCC_OFF = 2'b00,
      DSCC_RAW = 2'b01,
      DSCC_FMT_NORMAL = 2'b10,
      DSCC_FMT_ENH = 2'b11
   } dscc_mode_e;
   typedef logic [9:0] dscc_char_t;
endpackage : dscc_pkg

// ### dscc_char_code.sv
// Combinational symbol to character encoder and character checker.
`timescale 1ns/1ps
`include "dscc_regs.svh"
module dscc_char_code
   import dscc_pkg::*;
(
   input wire logic [6:0] sym_in,
   output dscc_char_t char_out,
   input wire dscc_char_t rx_char_in,
   output logic [6:0] rx_sym_out,
   output logic rx_err_out
);
   function automatic logic [2:0] dscc_zeros(input logic [6:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < 7; i++)
         if (!v[i])
            n = n + 3'h1;
      return n;
   endfunction : dscc_zeros

   logic [2:0] tx_cnt;
   logic [2:0] rx_cnt;
   // Index 0 is position one, sent first; symbol LSB first, count MSB first.
   always_comb
   begin
      tx_cnt = dscc_zeros(sym_in);
      char_out = {tx_cnt[0], tx_cnt[1], tx_cnt[2], sym_in};
      rx_sym_out = rx_char_in[6:0];
      rx_cnt = {rx_char_in[7], rx_char_in[8], rx_char_in[9]};
      rx_err_out = dscc_zeros(rx_char_in[6:0]) != rx_cnt;
   end
endmodule : dscc_char_code

// ### dscc_control.sv
// Selective-calling modem control, bit timing and character serialiser.
`timescale 1ns/1ps
`include "dscc_regs.svh"
module dscc_control
   import dscc_pkg::*;
#(
   parameter int BIT_CYCLES = `DSCC_BIT_CYCLES
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [15:0] modem_ctl_in,
   input wire logic [15:0] mode_ctl_in,
   input wire logic [15:0] first_program_word_in,
   input wire logic raw_sel_in,
   input wire logic distress_repeat_in,
   input wire logic expansion_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   input wire logic [6:0] tx_sym_in,
   output logic tx_bit_out,
   output logic tx_active_out,
   output logic [11:0] tone_hz_out,
   input wire logic rx_bit_in,
   output logic rx_valid_out,
   output logic [6:0] rx_sym_out,
   output logic rx_err_out,
   output logic packet_modem_en_out,
   output logic [8:0] packet_ctl_out,
   output logic expansion_en_out,
   output logic [1:0] mode_out
);
   logic sel;
   logic run;
   logic enh;
   logic [31:0] div_reg;
   logic tick;
   dscc_char_t tx_char;
   dscc_char_t rx_char_reg;
   dscc_char_t sh_reg;
   logic [3:0] tx_cnt_reg;
   logic [3:0] rx_cnt_reg;
   logic [6:0] held_reg;
   logic rx_err;
   logic [6:0] rx_sym;

   assign sel = modem_ctl_in[`DSCC_MCTL_SELECT_BIT];
   assign run = sel && mode_ctl_in[`DSCC_MODE_RUN_BIT];
   assign enh = first_program_word_in[`DSCC_PW0_ENH_BIT];
   assign tick = run && (div_reg == 32'(BIT_CYCLES - 1));
   assign tx_ready_out = run && (tx_cnt_reg == 4'h0) &&
      (!distress_repeat_in || !(enh && !raw_sel_in));

   dscc_char_code u_code (
      .sym_in(tx_ready_out ? tx_sym_in : held_reg),
      .char_out(tx_char),
      .rx_char_in(rx_char_reg),
      .rx_sym_out(rx_sym),
      .rx_err_out(rx_err)
   );

   // The packet modem sees nothing while selective calling owns the path.
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         packet_modem_en_out <= 1'b1;
         packet_ctl_out <= 9'h000;
         mode_out <= DSCC_OFF;
         expansion_en_out <= 1'b0;
      end
      else
      begin
         packet_modem_en_out <= !sel;
         packet_ctl_out <= sel ? 9'h000 :
            modem_ctl_in[`DSCC_MCTL_IGNORE_MSB:0];
         expansion_en_out <= sel && enh && !raw_sel_in && expansion_in;
         if (!sel)
            mode_out <= DSCC_OFF;
         else if (raw_sel_in)
            mode_out <= DSCC_RAW;
         else if (enh)
            mode_out <= DSCC_FMT_ENH;
         else
            mode_out <= DSCC_FMT_NORMAL;
      end
   end

   // Bit-rate divider gives one enable per 1200 bps bit.
   always_ff @(posedge clk_in)
   begin
      if (rst_in || !run || tick)
         div_reg <= 32'h0;
      else
         div_reg <= div_reg + 32'h1;
   end

   // Transmit serialiser; enhanced distress resends the held symbol.
   always_ff @(posedge clk_in)
   begin
      if (rst_in || !run)
      begin
         tx_cnt_reg <= 4'h0;
         sh_reg <= '0;
         held_reg <= 7'h00;
         tx_active_out <= 1'b0;
         tx_bit_out <= 1'b0;
      end
      else if (tx_cnt_reg == 4'h0)
      begin
         if ((tx_ready_out && tx_valid_in) || !tx_ready_out)
         begin
            if (tx_ready_out)
               held_reg <= tx_sym_in;
            // A load on a bit edge sends position one at once.
            if (tick)
            begin
               tx_active_out <= 1'b1;
               tx_bit_out <= tx_char[0];
               sh_reg <= {1'b0, tx_char[9:1]};
               tx_cnt_reg <= 4'(`DSCC_CHAR_BITS - 1);
            end
            else
            begin
               sh_reg <= tx_char;
               tx_cnt_reg <= 4'(`DSCC_CHAR_BITS);
            end
         end
         // The tone stays on until the edge that ends the last bit.
         else if (tick)
            tx_active_out <= 1'b0;
      end
      else if (tick)
      begin
         tx_active_out <= 1'b1;
         tx_bit_out <= sh_reg[0];
         sh_reg <= {1'b0, sh_reg[9:1]};
         tx_cnt_reg <= tx_cnt_reg - 4'h1;
      end
   end

   assign tone_hz_out = !tx_active_out ? 12'h000 :
      tx_bit_out ? 12'(`DSCC_TONE_ONE_HZ) : 12'(`DSCC_TONE_ZERO_HZ);

   // Receive deserialiser; first bit lands in position one.
   always_ff @(posedge clk_in)
   begin
      if (rst_in || !run)
      begin
         rx_cnt_reg <= 4'h0;
         rx_char_reg <= '0;
         rx_valid_out <= 1'b0;
         rx_sym_out <= 7'h00;
         rx_err_out <= 1'b0;
      end
      else
      begin
         rx_valid_out <= 1'b0;
         if (rx_cnt_reg == 4'(`DSCC_CHAR_BITS))
         begin
            rx_valid_out <= 1'b1;
            rx_sym_out <= rx_sym;
            rx_err_out <= rx_err;
            rx_cnt_reg <= 4'h0;
         end
         else if (tick)
         begin
            rx_char_reg <= {rx_bit_in, rx_char_reg[9:1]};
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
         end
      end
   end

   property p_pkt_off;
      @(posedge clk_in) disable iff (rst_in)
      sel |=> !packet_modem_en_out;
   endproperty
   a_pkt_off: assert property (p_pkt_off) else $error("packet on");

   property p_halt;
      @(posedge clk_in) disable iff (rst_in)
      !run |=> !tx_active_out && rx_cnt_reg == 4'h0;
   endproperty
   a_halt: assert property (p_halt) else $error("not halted");

   property p_ignore;
      @(posedge clk_in) disable iff (rst_in)
      sel |=> packet_ctl_out == 9'h000;
   endproperty
   a_ignore: assert property (p_ignore) else $error("ctl leak");

   property p_enh;
      @(posedge clk_in) disable iff (rst_in)
      mode_out == DSCC_FMT_ENH |-> $past(enh);
   endproperty
   a_enh: assert property (p_enh) else $error("enh no bit");

   property p_exp;
      @(posedge clk_in) disable iff (rst_in)
      expansion_en_out |-> $past(enh);
   endproperty
   a_exp: assert property (p_exp) else $error("exp no enh");

   property p_tone;
      @(posedge clk_in) disable iff (rst_in)
      tx_active_out && !tx_bit_out |->
         tone_hz_out == 12'(`DSCC_TONE_ZERO_HZ);
   endproperty
   a_tone: assert property (p_tone) else $error("bad tone");

   property p_rxerr;
      @(posedge clk_in) disable iff (rst_in)
      rx_valid_out |-> rx_err_out == $past(rx_err);
   endproperty
   a_rxerr: assert property (p_rxerr) else $error("bad err");

   property p_bit;
      @(posedge clk_in) disable iff (rst_in)
      tick && tx_cnt_reg == 4'hA |=> tx_bit_out == $past(sh_reg[0]);
   endproperty
   a_bit: assert property (p_bit) else $error("bad first");
endmodule : dscc_control

// ### dscc_host_model.sv
// Host model that writes the selective-calling control words.
`timescale 1ns/1ps
module dscc_host_model
#(
   parameter int GAP = 8
)
(
   input wire logic clk_in,
   input wire logic sel_in,
   input wire logic run_in,
   input wire logic enh_in,
   input wire logic [8:0] low_in,
   output logic [15:0] mctl_out,
   output logic [15:0] mode_out,
   output logic [15:0] pw0_out
);
   int gap = 0;
   always @(posedge clk_in)
   begin
      mctl_out <= {4'h0, sel_in, 2'h0, low_in};
      pw0_out <= {5'h00, enh_in, 10'h000};
      if (!run_in)
      begin
         mode_out <= 16'h0000;
         gap <= GAP;
      end
      else if (gap > 0)
         gap <= gap - 1;
      else
         mode_out <= 16'h0004;
   end
endmodule : dscc_host_model

// ### dscc_tb.sv
// Self-checking testbench for the selective-calling codec control.
`timescale 1ns/1ps
module testbench;
   import dscc_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic sel = 0, run = 0, enh = 0, raw = 0, xp = 0, tv = 0, rb = 0;
   logic dr = 0;
   logic [8:0] low = 9'h000;
   logic [6:0] ts = 7'h00;
   logic [15:0] mc, md, pw;
   logic tr, tb, ta, rv, re, pe, xe;
   logic [6:0] rs;
   logic [11:0] tone;
   logic [8:0] pc;
   logic [1:0] mode;
   int n_errors = 0, cmp_count = 0, cyc = 0;
   always #4 clk_in = ~clk_in;
   dscc_host_model host (.clk_in(clk_in), .sel_in(sel), .run_in(run),
      .enh_in(enh), .low_in(low), .mctl_out(mc), .mode_out(md),
      .pw0_out(pw));
   dscc_control #(.BIT_CYCLES(4)) dut (.clk_in(clk_in), .rst_in(rst_in),
      .modem_ctl_in(mc), .mode_ctl_in(md), .first_program_word_in(pw),
      .raw_sel_in(raw), .distress_repeat_in(dr), .expansion_in(xp),
      .tx_valid_in(tv), .tx_ready_out(tr), .tx_sym_in(ts), .tx_bit_out(tb),
      .tx_active_out(ta), .tone_hz_out(tone), .rx_bit_in(rb),
      .rx_valid_out(rv), .rx_sym_out(rs), .rx_err_out(re),
      .packet_modem_en_out(pe), .packet_ctl_out(pc),
      .expansion_en_out(xe), .mode_out(mode));
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic w(input int n);
      repeat (n) @(posedge clk_in);
   endtask : w
   function automatic dscc_char_t enc(input logic [6:0] s);
      logic [2:0] z;
      z = 3'(7 - $countones(s));
      return {z[0], z[1], z[2], s};
   endfunction : enc
   task automatic t_ctl;
      @(posedge clk_in);
      low <= 9'h1A5;
      run <= 1'b1;
      w(14);
      @(negedge clk_in);
      chk(pe, 16'h0001);
      chk(pc, 16'h01A5);
      chk(mode, 16'h0000);
      @(posedge clk_in);
      sel <= 1'b1;
      low <= 9'h05A;
      w(4);
      @(negedge clk_in);
      chk(pe, 16'h0000);
      chk(pc, 16'h0000);
      chk(mode, 16'h0002);
      @(posedge clk_in);
      raw <= 1'b1;
      w(4);
      @(negedge clk_in);
      chk(mode, 16'h0001);
      @(posedge clk_in);
      raw <= 1'b0;
      enh <= 1'b1;
      xp <= 1'b1;
      w(4);
      @(negedge clk_in);
      chk(mode, 16'h0003);
      chk(xe, 16'h0001);
      @(posedge clk_in);
      enh <= 1'b0;
      w(4);
      @(negedge clk_in);
      chk(mode, 16'h0002);
      chk(xe, 16'h0000);
      $display("done control");
   endtask : t_ctl
   task automatic t_tx(input logic [6:0] s);
      dscc_char_t c;
      logic [39:0] e;
      logic [47:0] g;
      int hit;
      int na;
      c = enc(s);
      hit = 0;
      na = 0;
      g = '0;
      for (int i = 0; i < 40; i++)
         e = {e[38:0], c[i / 4]};
      @(posedge clk_in);
      tv <= 1'b1;
      ts <= s;
      do @(negedge clk_in); while (tr !== 1'b1);
      @(posedge clk_in);
      tv <= 1'b0;
      repeat (48)
      begin
         @(negedge clk_in);
         g = {g[46:0], tb};
         if (ta === 1'b1)
         begin
            na++;
            chk(tone, tb ? 12'h514 : 12'h834);
         end
         else
            chk(tone, 16'h0000);
      end
      for (int k = 0; k < 9; k++)
         if (g[47 - k -: 40] === e)
            hit = 1;
      chk(hit, 16'h0001);
      chk(na, 16'h0028);
      $display("done tx %0d", s);
   endtask : t_tx
   task automatic t_rpt(input logic [6:0] s);
      dscc_char_t c;
      logic [79:0] e;
      logic [87:0] g;
      int hit;
      int nr;
      c = enc(s);
      hit = 0;
      nr = 0;
      g = '0;
      for (int i = 0; i < 80; i++)
         e = {e[78:0], c[(i / 4) % 10]};
      @(posedge clk_in);
      enh <= 1'b1;
      tv <= 1'b1;
      ts <= s;
      do @(negedge clk_in); while (tr !== 1'b1);
      @(posedge clk_in);
      tv <= 1'b0;
      dr <= 1'b1;
      repeat (88)
      begin
         @(negedge clk_in);
         g = {g[86:0], tb};
         if (tr === 1'b1)
            nr++;
      end
      for (int k = 0; k < 9; k++)
         if (g[87 - k -: 80] === e)
            hit = 1;
      chk(nr, 16'h0000);
      chk(hit, 16'h0001);
      @(posedge clk_in);
      dr <= 1'b0;
      enh <= 1'b0;
      $display("done repeat %0d", s);
   endtask : t_rpt
   task automatic t_rx(input logic [6:0] s, input logic bad);
      dscc_char_t c;
      c = enc(s);
      c[9] = c[9] ^ bad;
      @(posedge clk_in);
      run <= 1'b0;
      rb <= c[0];
      w(4);
      @(negedge clk_in);
      chk(tr, 16'h0000);
      @(posedge clk_in);
      run <= 1'b1;
      do @(negedge clk_in); while (tr !== 1'b1);
      w(1);
      for (int i = 0; i < 10; i++)
      begin
         rb <= c[i];
         w(4);
      end
      do @(negedge clk_in); while (rv !== 1'b1);
      chk(rs, s);
      chk(re, bad);
      $display("done rx %0d", s);
   endtask : t_rx
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         $display("wrong value at %0t: timeout", $time);
         end_of_test();
      end
   end
   initial
   begin
      w(10);
      rst_in <= 1'b0;
      w(1);
      @(negedge clk_in);
      chk(pe, 16'h0001);
      chk(ta, 16'h0000);
      t_ctl();
      t_tx(7'h00);
      t_tx(7'h7F);
      t_tx(7'h55);
      t_tx(7'h2A);
      t_rpt(7'h63);
      t_rx(7'h63, 1'b0);
      t_rx(7'h0C, 1'b1);
      end_of_test();
   end
endmodule : testbench
